/* File: src/prst_pkg.sv */
// Purpose: Shared constants and types for the processor reset interface block
// Assumes: Single clock aclk at 25 MHz, synchronous active-low aresetn
// Notes: Notes on behaviour listed below
//
// Notes on behaviour
// - Core reset reinitialises only processor-block state, nothing outside it
// - Any core reset during operation halts execution and drops all processor state
// - Reset inputs perform the reset and record its type
// - Request outputs never reset anything; only asserted inputs do
// - Last-reset field reads 01 core, 10 chip, 11 system/power-on, else kept
// - Internal power-on asserts all four resets at least sixteen cycles
// - Each request stays high until two cycles after its input asserts
// - Requests raised by debug field or watchdog time-out with matching select
package prst_pkg;

  // Register bus geometry
  localparam int         ADDR_W        = 4;
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Field positions
  localparam int DBG_LSB    = 0;
  localparam int WDOG_LSB   = 4;
  localparam int LAST_LSB   = 0;
  localparam int CORE_BIT   = 4;
  localparam int POR_BIT    = 5;
  localparam int REQ_LSB    = 6;

  // Reset type codes
  localparam logic [1:0] TYPE_NONE   = 2'h0;
  localparam logic [1:0] TYPE_CORE   = 2'h1;
  localparam logic [1:0] TYPE_CHIP   = 2'h2;
  localparam logic [1:0] TYPE_SYSTEM = 2'h3;

  // Values after reset and cycle counts
  localparam logic [1:0] LAST_RESET_INIT = 2'h3;
  localparam int         POR_CYCLES      = 16;
  localparam int         REQ_HOLD_CYCLES = 2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Software-written control state
  typedef struct packed {
    logic [1:0] wdog;
    logic [1:0] dbg;
  } prst_ctrl_type;

  // Effective reset levels
  typedef struct packed {
    logic core;
    logic chip;
    logic sys;
    logic test;
  } prst_levels_type;

endpackage : prst_pkg

/* File: src/prst_req_hold.sv */
// Purpose: Holds one reset-request output until its reset input has been seen
// Assumes: trig and seen are synchronous to aclk
// Notes: A new trigger during the drain window keeps the request alive
`timescale 1ns/1ps
`default_nettype none
module prst_req_hold
  import prst_pkg::*;
#(
  parameter int HOLD = REQ_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Request source and matching reset level
  input  wire logic trig,
  input  wire logic seen,
  // Request output
  output var  logic request
);

  typedef enum logic [1:0] {IDLE, PENDING, DRAIN} prst_hold_state_type;

  prst_hold_state_type state;
  prst_hold_state_type next_state;
  logic [1:0]          cnt;
  logic [1:0]          next_cnt;
  logic                next_request;

  // Next state of the request holder
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      IDLE: begin
        if (trig) begin
          next_state = PENDING;
        end
      end
      PENDING: begin
        if (seen) begin
          next_state = DRAIN;
          next_cnt   = 2'h1;
        end
      end
      DRAIN: begin
        if (trig) begin
          next_state = PENDING;
        end else if (cnt >= 2'(HOLD)) begin
          next_state = IDLE;
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      default: next_state = IDLE;
    endcase
    next_request = (next_state != IDLE);
  end

  // Registers; survive core reset so the tail completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= IDLE;
      cnt     <= 2'h0;
      request <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      request <= next_request;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_req_tail_end: assert property (
    (request && $rose(seen) && !trig) ##1 !trig ##1 !trig |=> !request)
    else $error("request not dropped two cycles after reset input");

  a_req_stays: assert property (
    (request && !seen) |=> request)
    else $error("request dropped before reset input");

endmodule : prst_req_hold
`default_nettype wire

/* File: src/prst_top.sv */
// Purpose: Reset interface of the processor block with AXI4-Lite register access
// Assumes: Reset inputs driven by fabric logic on aclk; watchdog pulse on aclk
// Notes: Control at 0x0, status at 0x4; other addresses answer SLVERR
`timescale 1ns/1ps
`default_nettype none
module prst_top
  import prst_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Reset inputs from fabric
  input  wire logic              core_reset_in,
  input  wire logic              chip_reset_in,
  input  wire logic              system_reset_in,
  input  wire logic              scan_port_reset_n,
  // Watchdog time-out event
  input  wire logic              watchdog_timeout,
  // Reset requests to fabric
  output var  logic              core_reset_request,
  output var  logic              chip_reset_request,
  output var  logic              system_reset_request,
  // Resets into processor logic
  output var  logic              core_reset_out,
  output var  logic              test_reset_n_out
);

  prst_ctrl_type   ctrl, next_ctrl;
  prst_levels_type lvl;
  logic [4:0]      por_cnt, next_por_cnt;
  logic [1:0]      last_type, next_last_type, next_bresp, next_rresp;
  logic [2:0]      dbg_trig, wdt_trig, trig;
  logic [3:0]      aw_addr, next_aw_addr;
  logic [31:0]     w_data, next_w_data, next_rdata;
  logic            por_active, next_por_active, aw_got, next_aw_got, w_got, next_w_got;
  logic            w_lane0, next_w_lane0, next_bvalid, next_rvalid, do_write, ctrl_write;

  // Reset type code to one-hot request {system, chip, core}
  function automatic logic [2:0] type_onehot(input logic [1:0] code);
    case (code)
      TYPE_CORE:   type_onehot = 3'h1;
      TYPE_CHIP:   type_onehot = 3'h2;
      TYPE_SYSTEM: type_onehot = 3'h4;
      default:     type_onehot = 3'h0;
    endcase
  endfunction : type_onehot

  // Power-on sequencer: fixed length, not software-visible except status
  always_comb begin
    next_por_cnt    = por_cnt;
    next_por_active = por_active;
    if (por_active) begin
      next_por_cnt    = por_cnt + 5'h1;
      next_por_active = (por_cnt < 5'(POR_CYCLES - 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt    <= 5'h0;
      por_active <= 1'b1;
    end else begin
      por_cnt    <= next_por_cnt;
      por_active <= next_por_active;
    end
  end

  // Effective levels merge fabric inputs with the power-on sequence
  // active-low test reset
  assign lvl.core = core_reset_in | por_active;
  assign lvl.chip = chip_reset_in | por_active;
  assign lvl.sys  = system_reset_in | por_active;
  assign lvl.test = ~scan_port_reset_n | por_active;

  // Reset record and outputs to processor logic
  always_comb begin
    next_last_type = last_type;
    if (lvl.core && lvl.sys) begin
      next_last_type = TYPE_SYSTEM;
    end else if (lvl.core && lvl.chip) begin
      next_last_type = TYPE_CHIP;
    end else if (lvl.core) begin
      next_last_type = TYPE_CORE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_type        <= LAST_RESET_INIT;
      core_reset_out   <= 1'b1;
      test_reset_n_out <= 1'b0;
    end else begin
      last_type        <= next_last_type;
      core_reset_out   <= lvl.core;
      test_reset_n_out <= ~lvl.test;
    end
  end

  // Request sources; a core in reset raises none
  // debug and watchdog sources
  assign ctrl_write = do_write && (aw_addr == CTRL_OFFSET) && w_lane0;
  assign dbg_trig   = (ctrl_write && !lvl.core) ? type_onehot(w_data[DBG_LSB +: 2]) : 3'h0;
  assign wdt_trig   = (watchdog_timeout && !lvl.core) ? type_onehot(ctrl.wdog) : 3'h0;
  assign trig       = dbg_trig | wdt_trig;

  prst_req_hold u_core_req (.aclk(aclk), .aresetn(aresetn), .trig(trig[0]), .seen(lvl.core),
                            .request(core_reset_request));
  prst_req_hold u_chip_req (.aclk(aclk), .aresetn(aresetn), .trig(trig[1]), .seen(lvl.chip),
                            .request(chip_reset_request));
  prst_req_hold u_sys_req  (.aclk(aclk), .aresetn(aresetn), .trig(trig[2]), .seen(lvl.sys),
                            .request(system_reset_request));

  // Control register; processor state, so lost in any core reset
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_write) begin
      next_ctrl.dbg = w_data[DBG_LSB +: 2];
      next_ctrl.wdog = w_data[WDOG_LSB +: 2];
    end
    if (lvl.core) begin
      next_ctrl = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // AXI4-Lite slave: address and data in either order, one write at a time
  assign do_write = aw_got && w_got && !s_axi_bvalid;

  always_comb begin
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = {s_axi_awaddr[3:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got   = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      // Status is read-only; writes to it are quietly dropped
      next_bresp  = (aw_addr == CTRL_OFFSET || aw_addr == STATUS_OFFSET)
                    ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read path: one cycle from address to data
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0;
      next_rresp  = RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'h0})
        CTRL_OFFSET: begin
          next_rdata[DBG_LSB +: 2] = ctrl.dbg;
          next_rdata[WDOG_LSB +: 2] = ctrl.wdog;
        end
        STATUS_OFFSET: begin
          next_rdata[LAST_LSB +: 2] = last_type;
          next_rdata[CORE_BIT]      = core_reset_out;
          next_rdata[POR_BIT]       = por_active;
          next_rdata[REQ_LSB +: 3]  = {system_reset_request, chip_reset_request,
                                       core_reset_request};
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  // Ready lines are registered, so each channel takes at most one beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_lane0       <= next_w_lane0;
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready  <= !next_w_got && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_por_sixteen: assert property (
    $rose(aresetn) |-> core_reset_out [*8] ##1 core_reset_out [*8])
    else $error("power-on core reset shorter than sixteen cycles");
  a_por_test_low: assert property (
    por_active |=> !test_reset_n_out && core_reset_out)
    else $error("power-on did not hold test and core reset");
  a_last_core: assert property (
    (core_reset_in && !chip_reset_in && !system_reset_in && !por_active)
      |=> last_type == TYPE_CORE)
    else $error("core reset not recorded as 01");
  a_last_chip: assert property (
    (core_reset_in && chip_reset_in && !system_reset_in && !por_active)
      |=> last_type == TYPE_CHIP)
    else $error("chip reset not recorded as 10");
  a_last_system: assert property (
    (core_reset_in && system_reset_in) |=> last_type == TYPE_SYSTEM)
    else $error("system reset not recorded as 11");
  a_last_keep: assert property (
    !lvl.core |=> $stable(last_type))
    else $error("last reset type changed without reset");
  a_req_no_reset: assert property (
    (!core_reset_in && !por_active) |=> !core_reset_out)
    else $error("core reset without core reset input");
  a_halt_clear: assert property (
    lvl.core |=> core_reset_out && ctrl == '0)
    else $error("processor state kept through core reset");
  a_dbg_raise: assert property (
    dbg_trig[1] |=> chip_reset_request)
    else $error("debug write 10 did not raise chip request");
  a_wdt_raise: assert property (
    (watchdog_timeout && !lvl.core && ctrl.wdog == TYPE_SYSTEM) |=> system_reset_request)
    else $error("watchdog time-out did not raise system request");

  c_core_cycle: cover property (core_reset_request ##[1:100] $fell(core_reset_request));
  c_chip_reset: cover property (core_reset_in && chip_reset_in && !system_reset_in);
  c_wdt_req:    cover property (watchdog_timeout && ctrl.wdog != TYPE_NONE && !lvl.core);
  c_bad_addr:   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : prst_top
`default_nettype wire

/* File: testbench/prst_fabric_model.sv */
// Purpose: Fabric reset generator facing the processor reset interface
// Assumes: Requests and bench sources are levels synchronous to aclk
// Notes: Holds a pattern HOLD cycles, then drops all lines together
`timescale 1ns/1ps
`default_nettype none
module prst_fabric_model #(
  parameter int HOLD = 8
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Request sources: block requests, bench sources, answer delay
  input  wire logic [2:0] req,
  input  wire logic [2:0] src,
  input  wire logic [3:0] delay,
  // Reset lines to the block
  output var  logic       core_rst,
  output var  logic       chip_rst,
  output var  logic       sys_rst,
  output var  logic       test_rst_n
);
  logic [2:0] kind;
  int         wait_cnt;
  int         hold_cnt;

  // requests map to patterns on the clock
  // source 5 drops core on purpose; source 4 drives test line low
  always @(posedge aclk) begin
    if (!aresetn) begin
      {core_rst, chip_rst, sys_rst, test_rst_n} <= 4'h1;
      kind     <= 3'h0;
      hold_cnt <= 0;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
      if (hold_cnt == 1) begin
        {core_rst, chip_rst, sys_rst, test_rst_n} <= 4'h1;
        kind <= 3'h0;
      end
    end else if (kind != 3'h0) begin
      wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 0) begin
        // chip and system lines fan out beyond block
        core_rst   <= (kind != 3'h5);
        chip_rst   <= (kind >= 3'h2);
        sys_rst    <= (kind >= 3'h3);
        test_rst_n <= (kind != 3'h4);
        hold_cnt   <= HOLD;
      end
    end else if (src != 3'h0 || req != 3'h0) begin
      // Bench source wins; otherwise the widest requested type
      kind     <= (src != 3'h0) ? src : req[2] ? 3'h3 : req[1] ? 3'h2 : 3'h1;
      wait_cnt <= int'(delay);
    end
  end
endmodule : prst_fabric_model
`default_nettype wire

/* File: testbench/test_prst_top.sv */
// Purpose: Self-checking bench for the processor reset interface
// Assumes: Fabric model answers requests with cumulative reset patterns
// Notes: Bus answers are noted in queues and matched by a monitor process
`timescale 1ns/1ps
`default_nettype none
module test_prst_top
  import prst_pkg::*;
();
  logic              aclk, aresetn, watchdog_timeout;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, delay;
  logic [1:0]        bresp, rresp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic              core_reset_in, chip_reset_in, system_reset_in, scan_port_reset_n;
  logic              core_reset_request, chip_reset_request, system_reset_request;
  logic              core_reset_out, test_reset_n_out;
  logic [2:0]        src;
  logic [15:0]       rnd;
  logic [1:0]        exp_b[$];
  logic [33:0]       exp_r[$];
  int                errors, checks, cycles, n, t0;

  prst_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_reset_in(core_reset_in), .chip_reset_in(chip_reset_in),
    .system_reset_in(system_reset_in), .scan_port_reset_n(scan_port_reset_n),
    .watchdog_timeout(watchdog_timeout), .core_reset_request(core_reset_request),
    .chip_reset_request(chip_reset_request), .system_reset_request(system_reset_request),
    .core_reset_out(core_reset_out), .test_reset_n_out(test_reset_n_out));

  prst_fabric_model #(.HOLD(8)) fab (.aclk(aclk), .aresetn(aresetn), .src(src),
    .req({system_reset_request, chip_reset_request, core_reset_request}), .delay(delay),
    .core_rst(core_reset_in), .chip_rst(chip_reset_in), .sys_rst(system_reset_in),
    .test_rst_n(scan_port_reset_n));

  // Free-running 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] r);
    bit ad;
    bit wd;
    exp_b.push_back(r);
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad |= (awready === 1'b1);
      wd |= (wready === 1'b1);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_read

  task automatic pulse_wd();
    @(posedge aclk);
    watchdog_timeout <= 1'b1;
    @(posedge aclk);
    watchdog_timeout <= 1'b0;
  endtask : pulse_wd

  // Wait for a request, then time its drop against the fabric answer
  task automatic run_reset(input logic [1:0] t);
    logic [2:0] rq;
    int         k;
    int         c;
    int         f;
    bit         hit;
    k = 0;
    c = 0;
    f = 0;
    hit = 0;
    do begin
      @(negedge aclk);
      k++;
      rq = {system_reset_request, chip_reset_request, core_reset_request};
    end while (rq == 3'h0 && k < 20);
    check("request", 34'(rq), 34'(3'h1 << (t - 2'h1)));
    check("self_reset", 34'(core_reset_out), 34'h0);
    k = 0;
    while (f == 0 && k < 40) begin
      @(negedge aclk);
      k++;
      if (c == 0 && core_reset_in === 1'b1) c = k;
      hit |= (core_reset_out === 1'b1);
      if ({system_reset_request, chip_reset_request, core_reset_request} === 3'h0) f = k;
    end
    check("request_drop", 34'(f - c), 34'h3);
    check("core_reset", 34'(hit), 34'h1);
    k = 0;
    while (core_reset_out !== 1'b0 && k < 40) begin
      @(negedge aclk);
      k++;
    end
    axi_read(STATUS_OFFSET, {2'h0, 30'h0, t});
    axi_read(CTRL_OFFSET, 34'h0);
  endtask : run_reset

  // Bench-made fabric resets, legal and deliberately broken
  task automatic use_src(input logic [2:0] s, input logic hc, input logic ht,
                         input logic [1:0] l);
    bit c;
    bit tl;
    c = 0;
    tl = 0;
    @(posedge aclk);
    src <= s;
    @(posedge aclk);
    src <= 3'h0;
    repeat (30) begin
      @(negedge aclk);
      c |= (core_reset_out === 1'b1);
      tl |= (test_reset_n_out === 1'b0);
    end
    check("core_out", 34'(c), 34'(hc));
    check("test_out", 34'(tl), 34'(ht));
    axi_read(STATUS_OFFSET, 34'(l));
  endtask : use_src

  // Match each bus answer with the oldest noted expectation
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && bvalid === 1'b1 && bready === 1'b1 && exp_b.size() > 0)
      check("bresp", 34'(bresp), 34'(exp_b.pop_front()));
    if (aresetn === 1'b1 && rvalid === 1'b1 && rready === 1'b1 && exp_r.size() > 0)
      check("read", {rresp, rdata}, exp_r.pop_front());
  end

  // Hang guard, far above the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, watchdog_timeout} = 7'h0;
    {awaddr, araddr, wdata, wstrb, src} = '0;
    delay = 4'h3;
    rnd = 16'h9723; // Seed 38691
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    t0 = 0;
    @(negedge aclk);
    while (core_reset_out === 1'b1 && n < 40) begin
      t0 += int'(test_reset_n_out === 1'b0);
      n++;
      @(negedge aclk);
    end
    check("por_len", 34'(n >= 16 && n <= 19), 34'h1);
    check("por_test", 34'(t0 >= 16), 34'h1);
    pulse_wd();
    repeat (5) @(negedge aclk);
    check("no_request", 34'({system_reset_request, chip_reset_request, core_reset_request}), 34'h0);
    axi_read(STATUS_OFFSET, 34'h3);
    axi_read(CTRL_OFFSET, 34'h0);
    axi_write(CTRL_OFFSET, {rnd, 16'h0030}, 4'hf, RESP_OKAY);
    axi_write(CTRL_OFFSET, {rnd, 16'h0001}, 4'he, RESP_OKAY);
    axi_read(CTRL_OFFSET, 34'h30);
    check("quiet", 34'(core_reset_request), 34'h0);
    axi_write(4'h8, 32'h3, 4'hf, RESP_SLVERR);
    axi_read(4'hc, {RESP_SLVERR, 32'h0});
    axi_write(STATUS_OFFSET, 32'h3, 4'hf, RESP_OKAY);
    axi_read(STATUS_OFFSET, 34'h3);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      rnd = lfsr(rnd);
      delay <= 4'h3 + {1'b0, rnd[2:0]};
      if (i < 3) axi_write(CTRL_OFFSET, {rnd, 14'h0, 2'(i + 1)}, 4'hf, RESP_OKAY);
      else axi_write(CTRL_OFFSET, {rnd, 10'h0, 2'(i - 2), 4'h0}, 4'hf, RESP_OKAY);
      if (i >= 3) pulse_wd();
      run_reset(2'(i % 3 + 1));
    end
    use_src(3'h1, 1'b1, 1'b0, 2'h1);
    use_src(3'h5, 1'b0, 1'b0, 2'h1);
    use_src(3'h4, 1'b1, 1'b1, 2'h3);
    stop_test();
  end
endmodule : test_prst_top
`default_nettype wire
